// [design/dsd_status_cmds.sv]
// What this block does
// [RL1] Escape blocks normal commands except diagnostic reset; accepts tags 30 to 37.
// [RL2] Escape stops the sector counter and sets summary bit 7.
// [RL3] Diagnostic reset or device initialize leaves escape.
// [RL4] Head upper query returns all zeros.
// [RL5] Head lower query returns the head address register.
// [RL6] Cylinder upper query returns high cylinder position bits.
// [RL7] Cylinder lower query returns eight low cylinder position bits.
// [RL8] Angular query returns sector count captured when the tag arrived.
// [RL9] Unit number query returns the 8-bit unit identifier.
// [RL10] Type query returns a fixed wired type code.
// [RL11] Summary query answers outside escape, seized or not, pack or not.
// [RL12] Summary bits: 5 standby, 6 seized here, 7 seized by other.
// [RL13] Positioner busy on seek, zero seek, 10 ms after offset; drop notifies.
// [RL14] Single-port drive always reports seized.
// [RL15] First detail byte clears on its read, initialize or check switch.
// [RL16] Any first detail error sets summary interface error bit 3.
// [RL17] Output transfers flag even parity while host strobe low, read strobe high.
// [RL18] Second detail errors set device failure; clear on read, initialize, check.
// [RL19] Second detail: supply loss bit 0 sets pack unsafe; spindle loss unloads.
// [RL20] Outside escape, index before sector 127 latches sector error, device failure.
// [RL21] Travel past 822 or below 000, not in return to zero, flags interface error.
// [RL22] Fourth detail records last seek direction; recalibrate, reset leave it.
`timescale 1ns/1ps
`default_nettype none
`include "dsd_map.svh"
module dsd_status_cmds
    import dsd_pkg::*;
#(
    parameter int unsigned BUSY_CYCLES =
        `DSD_POS_BUSY_MS * 1000000 / `DSD_CLK_PERIOD_NS
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [5:0] cmd_tag,
    input wire logic cmd_strobe,
    input wire logic host_write_strobe,
    input wire logic [7:0] data_in,
    input wire logic parity_in,
    output logic [7:0] data_out,
    output logic parity_out,
    output logic data_oe,
    output logic drive_read_strobe,
    input wire logic dev_init,
    input wire logic check_switch,
    input wire logic [7:0] head_addr,
    input wire logic [9:0] cyl_pos,
    input wire logic [7:0] unit_id,
    input wire logic standby,
    input wire logic seized_here,
    input wire logic seized_other,
    input wire logic single_port,
    input wire dsd_fault_t faults,
    input wire dsd_pos_t pos,
    output logic diag_escape,
    output logic pos_busy,
    output logic device_event_notice,
    output logic pack_unsafe,
    output logic heads_unload,
    output logic interface_error
);
    dsd_xfer_state_t state_q, state_d;
    logic strobe_q, sw_q;
    logic esc_q, esc_d;
    logic rd_q, rd_d, oe_q, oe_d;
    logic [7:0] buf_q, buf_d;
    logic [7:0] d1_q, d1_d, d2_q, d2_d, d3_q, d3_d, d4_q, d4_d;
    logic unsafe_q, unsafe_d, unload_q, unload_d, iferr_q, iferr_d;
    logic [6:0] sect_count;
    logic sect_err;
    logic cmd_new, allowed, esc_enter, step;
    logic [1:0] cls;
    logic [7:0] summary;

    // Escape passes only diagnostic reset and the test range
    function automatic logic tag_allowed(input logic esc, input logic [5:0] t);
        logic diag_range;
        diag_range = (t >= `DSD_TAG_DIAG_FIRST) && (t <= `DSD_TAG_DIAG_LAST);
        if (esc)
            tag_allowed = diag_range || (t == `DSD_TAG_DIAG_RESET); // [RL1]
        else
            tag_allowed = !diag_range;
    endfunction

    function automatic logic accepted(input logic n, input logic a, input logic [5:0] t,
        input logic [5:0] want);
        accepted = n && a && (t == want);
    endfunction

    assign cmd_new = cmd_strobe && !strobe_q;
    assign allowed = tag_allowed(esc_q, cmd_tag);
    assign cls = cmd_tag[5:4];
    assign esc_enter = accepted(cmd_new, allowed, cmd_tag, `DSD_TAG_DIAG_ESCAPE);
    assign step = accepted(cmd_new, allowed, cmd_tag, `DSD_TAG_SECT_STEP);

    // Summary byte is live status, built fresh each cycle
    always_comb
    begin
        summary = 8'h00; // [RL11]
        summary[`DSD_SUM_DEV_FAIL] = (d2_q != 8'h00) || d3_q[`DSD_D3_SECTOR]; // [RL18] [RL20]
        summary[`DSD_SUM_IF_ERR] = (d1_q != 8'h00) || d3_q[`DSD_D3_EOT]; // [RL16] [RL21]
        summary[`DSD_SUM_POS_BUSY] = pos_busy;
        summary[`DSD_SUM_STANDBY] = standby; // [RL12]
        summary[`DSD_SUM_SEIZED] = seized_here || single_port; // [RL12] [RL14]
        summary[`DSD_SUM_DIAG] = esc_q || seized_other; // [RL2] [RL12]
    end

    dsd_sector_counter u_sector (
        .core_clk(core_clk),
        .rst(rst),
        .escape(esc_q),
        .escape_enter(esc_enter),
        .sector_pulse(faults.sector_pulse),
        .index_pulse(faults.index_pulse),
        .step(step),
        .count_q(sect_count),
        .sector_err_q(sect_err)
    );

    dsd_pos_busy #(
        .BUSY_CYCLES(BUSY_CYCLES)
    ) u_busy (
        .core_clk(core_clk),
        .rst(rst),
        .pos(pos),
        .busy_q(pos_busy),
        .event_q(device_event_notice)
    );

    // Handshake, escape mode and answer buffer
    always_comb
    begin
        state_d = state_q;
        esc_d = esc_q;
        rd_d = rd_q;
        oe_d = oe_q;
        buf_d = buf_q;
        if (esc_enter)
            esc_d = 1'b1; // [RL1]
        if (accepted(cmd_new, allowed, cmd_tag, `DSD_TAG_DIAG_RESET) || dev_init)
            esc_d = 1'b0; // [RL3]
        unique case (state_q)
            DSD_IDLE:
            begin
                if (cmd_new && !allowed)
                    state_d = DSD_HOLD; // [RL1]
                else if (cmd_new && cls == `DSD_CLASS_INPUT)
                begin
                    unique case (cmd_tag)
                        `DSD_TAG_HEAD_UP: buf_d = 8'h00; // [RL4]
                        `DSD_TAG_HEAD_LO: buf_d = head_addr; // [RL5]
                        `DSD_TAG_CYL_UP: buf_d = {6'h00, cyl_pos[9:8]}; // [RL6]
                        `DSD_TAG_CYL_LO: buf_d = cyl_pos[7:0]; // [RL7]
                        `DSD_TAG_ANGULAR: buf_d = {1'b0, sect_count}; // [RL8]
                        `DSD_TAG_UNIT_NUM: buf_d = unit_id; // [RL9]
                        `DSD_TAG_UNIT_TYPE: buf_d = `DSD_TYPE_CODE; // [RL10]
                        `DSD_TAG_SUMMARY: buf_d = summary; // [RL11]
                        `DSD_TAG_DETAIL1: buf_d = d1_q;
                        `DSD_TAG_DETAIL2: buf_d = d2_q;
                        `DSD_TAG_DETAIL3: buf_d = d3_q;
                        `DSD_TAG_DETAIL4: buf_d = d4_q;
                        default: buf_d = 8'h00;
                    endcase
                    oe_d = 1'b1;
                    rd_d = 1'b1;
                    state_d = DSD_IN_DRIVE;
                end
                else if (cmd_new && cls == `DSD_CLASS_OUTPUT)
                    state_d = DSD_OUT_WAIT;
                else if (cmd_new)
                    state_d = DSD_HOLD;
            end
            DSD_IN_DRIVE:
            begin
                if (host_write_strobe)
                begin
                    rd_d = 1'b0;
                    state_d = DSD_HOLD;
                end
            end
            DSD_OUT_WAIT:
            begin
                if (host_write_strobe)
                    rd_d = 1'b1;
                else if (rd_q && sw_q)
                begin
                    rd_d = 1'b0;
                    state_d = DSD_HOLD;
                end
            end
            DSD_HOLD:
            begin
                if (!cmd_strobe)
                begin
                    oe_d = 1'b0;
                    rd_d = 1'b0;
                    state_d = DSD_IDLE;
                end
            end
        endcase
        if (!cmd_strobe && state_q != DSD_IDLE)
        begin
            oe_d = 1'b0;
            rd_d = 1'b0;
            state_d = DSD_IDLE;
        end
    end

    // Error latches: a new error in the same cycle as its clear survives
    always_comb
    begin
        logic par_bad, rd1, rd2, rd3, clr;
        logic eot;
        par_bad = (state_q == DSD_OUT_WAIT) && rd_q && !host_write_strobe
            && !(^{parity_in, data_in}); // [RL17]
        clr = dev_init || check_switch;
        rd1 = accepted(cmd_new, allowed, cmd_tag, `DSD_TAG_DETAIL1);
        rd2 = accepted(cmd_new, allowed, cmd_tag, `DSD_TAG_DETAIL2);
        rd3 = accepted(cmd_new, allowed, cmd_tag, `DSD_TAG_DETAIL3);
        eot = !faults.rtz_active && ((cyl_pos > `DSD_CYL_MAX) || faults.rev_past_zero);
        d1_d = (rd1 || clr) ? 8'h00 : d1_q; // [RL15]
        d1_d[`DSD_D1_DATA_PAR] = d1_d[`DSD_D1_DATA_PAR] || par_bad; // [RL17]
        d2_d = (rd2 || clr) ? 8'h00 : d2_q; // [RL18]
        d2_d[`DSD_D2_SUPPLY] = d2_d[`DSD_D2_SUPPLY] || faults.supply_loss; // [RL19]
        d2_d[`DSD_D2_SPINDLE] = d2_d[`DSD_D2_SPINDLE] || faults.spindle_loss; // [RL19]
        d3_d = (rd3 || clr) ? 8'h00 : d3_q;
        d3_d[`DSD_D3_SECTOR] = d3_d[`DSD_D3_SECTOR] || sect_err; // [RL20]
        d3_d[`DSD_D3_EOT] = d3_d[`DSD_D3_EOT] || eot; // [RL21]
        d4_d = d4_q;
        if (accepted(cmd_new, allowed, cmd_tag, `DSD_TAG_SEEK_FWD_LO))
        begin
            d4_d[`DSD_D4_LAST_FWD] = 1'b1; // [RL22]
            d4_d[`DSD_D4_LAST_REV] = 1'b0;
        end
        else if (accepted(cmd_new, allowed, cmd_tag, `DSD_TAG_SEEK_REV_LO))
        begin
            d4_d[`DSD_D4_LAST_FWD] = 1'b0; // [RL22]
            d4_d[`DSD_D4_LAST_REV] = 1'b1;
        end
        unsafe_d = (unsafe_q && !check_switch) || faults.supply_loss; // [RL19]
        unload_d = d2_d[`DSD_D2_SPINDLE]; // [RL19]
        iferr_d = (d1_d != 8'h00) || d3_d[`DSD_D3_EOT]; // [RL16] [RL21]
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= DSD_IDLE;
            strobe_q <= 1'b0;
            sw_q <= 1'b0;
            esc_q <= 1'b0;
            rd_q <= 1'b0;
            oe_q <= 1'b0;
            buf_q <= 8'h00;
            d1_q <= 8'h00;
            d2_q <= 8'h00;
            d3_q <= 8'h00;
            d4_q <= 8'h00;
            unsafe_q <= 1'b0;
            unload_q <= 1'b0;
            iferr_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            strobe_q <= cmd_strobe;
            sw_q <= host_write_strobe;
            esc_q <= esc_d;
            rd_q <= rd_d;
            oe_q <= oe_d;
            buf_q <= buf_d;
            d1_q <= d1_d;
            d2_q <= d2_d;
            d3_q <= d3_d;
            d4_q <= d4_d;
            unsafe_q <= unsafe_d;
            unload_q <= unload_d;
            iferr_q <= iferr_d;
        end
    end

    // Outputs straight from flops; odd parity added to the answer byte
    assign data_out = buf_q;
    assign parity_out = ~^buf_q;
    assign data_oe = oe_q;
    assign drive_read_strobe = rd_q;
    assign diag_escape = esc_q;
    assign pack_unsafe = unsafe_q;
    assign heads_unload = unload_q;
    assign interface_error = iferr_q;

    a_esc_enter: assert property (@(posedge core_clk) disable iff (rst)
        esc_enter && !dev_init |=> esc_q) // [RL1]
        else $error("escape command not taken");
    a_esc_leave: assert property (@(posedge core_clk) disable iff (rst)
        dev_init |=> !esc_q) // [RL3]
        else $error("initialize did not leave escape");
    a_esc_block: assert property (@(posedge core_clk) disable iff (rst)
        cmd_new && esc_q && cmd_tag == `DSD_TAG_SUMMARY |=> !oe_q && state_q == DSD_HOLD) // [RL1]
        else $error("normal command ran in escape");
    a_head_answer: assert property (@(posedge core_clk) disable iff (rst)
        cmd_new && allowed && state_q == DSD_IDLE && cmd_tag == `DSD_TAG_HEAD_LO
        |=> oe_q && buf_q == $past(head_addr)) // [RL5]
        else $error("head address answer wrong");
    a_zero_answer: assert property (@(posedge core_clk) disable iff (rst)
        cmd_new && allowed && state_q == DSD_IDLE && cmd_tag == `DSD_TAG_HEAD_UP
        |=> buf_q == 8'h00) // [RL4]
        else $error("head upper answer not zero");
    a_par_flag: assert property (@(posedge core_clk) disable iff (rst)
        state_q == DSD_OUT_WAIT && rd_q && !host_write_strobe
        && !(^{parity_in, data_in}) |=> d1_q[`DSD_D1_DATA_PAR] && iferr_q) // [RL17]
        else $error("data parity error not latched");
    a_d1_clear: assert property (@(posedge core_clk) disable iff (rst)
        check_switch && state_q != DSD_OUT_WAIT |=> d1_q == 8'h00) // [RL15]
        else $error("first detail byte not cleared");
    a_supply_unsafe: assert property (@(posedge core_clk) disable iff (rst)
        faults.supply_loss |=> pack_unsafe && d2_q[`DSD_D2_SUPPLY]) // [RL19]
        else $error("supply loss not latched");
    a_seek_dir: assert property (@(posedge core_clk) disable iff (rst)
        accepted(cmd_new, allowed, cmd_tag, `DSD_TAG_SEEK_REV_LO)
        |=> d4_q[`DSD_D4_LAST_REV] && !d4_q[`DSD_D4_LAST_FWD]) // [RL22]
        else $error("seek direction not recorded");
    a_seized_single: assert property (@(posedge core_clk) disable iff (rst)
        single_port |-> summary[`DSD_SUM_SEIZED]) // [RL14]
        else $error("single port not seized");
endmodule
`default_nettype wire

// [design/dsd_map.svh]
`ifndef DSD_MAP_SVH
`define DSD_MAP_SVH
// Command tags
`define DSD_TAG_SEEK_FWD_LO 6'h03
`define DSD_TAG_SEEK_REV_LO 6'h05
`define DSD_TAG_DIAG_RESET 6'h15
`define DSD_TAG_DIAG_ESCAPE 6'h1f
`define DSD_TAG_HEAD_UP 6'h20
`define DSD_TAG_HEAD_LO 6'h21
`define DSD_TAG_CYL_UP 6'h22
`define DSD_TAG_CYL_LO 6'h23
`define DSD_TAG_ANGULAR 6'h24
`define DSD_TAG_UNIT_NUM 6'h26
`define DSD_TAG_UNIT_TYPE 6'h27
`define DSD_TAG_SUMMARY 6'h28
`define DSD_TAG_DETAIL1 6'h29
`define DSD_TAG_DETAIL2 6'h2a
`define DSD_TAG_DETAIL3 6'h2b
`define DSD_TAG_DETAIL4 6'h2c
`define DSD_TAG_DIAG_FIRST 6'h30
`define DSD_TAG_DIAG_LAST 6'h37
`define DSD_TAG_SECT_STEP 6'h33
// Command class field (top two tag bits)
`define DSD_CLASS_OUTPUT 2'h0
`define DSD_CLASS_INPUT 2'h2
// Summary status bit positions
`define DSD_SUM_DEV_FAIL 1
`define DSD_SUM_IF_ERR 3
`define DSD_SUM_POS_BUSY 4
`define DSD_SUM_STANDBY 5
`define DSD_SUM_SEIZED 6
`define DSD_SUM_DIAG 7
// Detail byte bit positions
`define DSD_D1_DATA_PAR 0
`define DSD_D2_SUPPLY 0
`define DSD_D2_SPINDLE 2
`define DSD_D3_SECTOR 0
`define DSD_D3_EOT 1
`define DSD_D4_LAST_REV 0
`define DSD_D4_LAST_FWD 1
// Geometry and limits
`define DSD_CYL_MAX 10'h336
`define DSD_SECT_LAST 7'h7f
`define DSD_TYPE_CODE 8'h5a
// Timing
`define DSD_CLK_PERIOD_NS 10
`define DSD_POS_BUSY_MS 10
`endif

// [design/dsd_pkg.sv]
package dsd_pkg;
    // Host handshake phases
    typedef enum logic [1:0] {
        DSD_IDLE = 2'b00,
        DSD_IN_DRIVE = 2'b01,
        DSD_OUT_WAIT = 2'b10,
        DSD_HOLD = 2'b11
    } dsd_xfer_state_t;

    // Fault and event inputs from the rest of the drive
    typedef struct packed {
        logic supply_loss;
        logic spindle_loss;
        logic index_pulse;
        logic sector_pulse;
        logic rev_past_zero;
        logic rtz_active;
    } dsd_fault_t;

    // Positioner condition inputs
    typedef struct packed {
        logic seek_active;
        logic zero_len_seek;
        logic offset_shift;
    } dsd_pos_t;
endpackage

// [design/dsd_sector_counter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dsd_map.svh"
module dsd_sector_counter
    import dsd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic escape,
    input wire logic escape_enter,
    input wire logic sector_pulse,
    input wire logic index_pulse,
    input wire logic step,
    output logic [6:0] count_q,
    output logic sector_err_q
);
    logic [6:0] count_d;
    logic sector_err_d;

    // Disk pulses are ignored in escape; only the diagnostic step moves it
    always_comb
    begin
        count_d = count_q;
        sector_err_d = 1'b0;
        if (escape_enter)
            count_d = 7'h00; // [RL2]
        else if (escape)
        begin
            if (step)
                count_d = count_q + 7'h01; // [RL2]
        end
        else if (index_pulse)
        begin
            count_d = 7'h00;
            sector_err_d = (count_q != `DSD_SECT_LAST); // [RL20]
        end
        else if (sector_pulse)
            count_d = count_q + 7'h01;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            count_q <= 7'h00;
            sector_err_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            sector_err_q <= sector_err_d;
        end
    end

    a_sect_frozen: assert property (@(posedge core_clk) disable iff (rst)
        escape && !escape_enter && !step |=> count_q == $past(count_q)) // [RL2]
        else $error("sector counter moved during escape");
endmodule
`default_nettype wire

// [design/dsd_pos_busy.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dsd_map.svh"
module dsd_pos_busy
    import dsd_pkg::*;
#(
    parameter int unsigned BUSY_CYCLES = 1000000
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire dsd_pos_t pos,
    output logic busy_q,
    output logic event_q
);
    logic [19:0] timer_q;
    logic [19:0] timer_d;
    logic busy_d;
    logic event_d;

    // Offset shift restarts the settle window; busy drop raises the notice
    always_comb
    begin
        timer_d = timer_q;
        if (pos.offset_shift)
            timer_d = 20'(BUSY_CYCLES); // Full window: busy stands BUSY_CYCLES cycles [RL13]
        else if (timer_q != 20'h00000)
            timer_d = timer_q - 20'h00001;
        busy_d = pos.seek_active || pos.zero_len_seek || (timer_d != 20'h00000)
            || pos.offset_shift; // [RL13]
        event_d = busy_q && !busy_d; // [RL13]
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            timer_q <= 20'h00000;
            busy_q <= 1'b0;
            event_q <= 1'b0;
        end
        else
        begin
            timer_q <= timer_d;
            busy_q <= busy_d;
            event_q <= event_d;
        end
    end

    a_busy_notice: assert property (@(posedge core_clk) disable iff (rst)
        $fell(busy_q) |-> event_q) // [RL13]
        else $error("busy dropped without event notice");
    a_busy_shift: assert property (@(posedge core_clk) disable iff (rst)
        pos.offset_shift |=> busy_q) // [RL13]
        else $error("offset shift did not raise busy");
endmodule
`default_nettype wire

// [sim/dsd_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dsd_host_model
    import dsd_pkg::*;
(
    input wire logic core_clk,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic drive_read_strobe,
    output logic [5:0] cmd_tag,
    output logic cmd_strobe,
    output logic host_write_strobe,
    output logic [7:0] data_in,
    output logic parity_in
);
    logic drv = 1'b0;
    logic bad = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [7:0] pat = 8'h96;
    // Released lines toggle, so a stale byte never passes for a driven one
    always @(posedge core_clk) pat <= ~pat;
    assign data_in = drv ? wd : pat;
    assign parity_in = drv ? (~^wd ^ bad) : pat[0]; // Odd over nine lines
    initial
    begin
        cmd_tag = 6'h00;
        cmd_strobe = 1'b0;
        host_write_strobe = 1'b0;
    end
    // Bounded wait for the read strobe to reach a level
    task automatic wait_rd(input logic lvl, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        while (n < 8 && !ok)
        begin
            @(posedge core_clk) #1;
            ok = (drive_read_strobe === lvl);
            n++;
        end
    endtask
    // Input transfer; byte taken when the read strobe is seen up
    task automatic in_cmd(input logic [5:0] tag, output logic [7:0] d, output logic ok);
        logic g;
        @(posedge core_clk) #1;
        cmd_tag = tag;
        cmd_strobe = 1'b1;
        wait_rd(1'b1, ok);
        // An undriven answer comes back inverted so it can never match
        d = data_oe ? data_out : ~data_out;
        if (ok)
        begin
            host_write_strobe = 1'b1;
            wait_rd(1'b0, g);
            host_write_strobe = 1'b0;
        end
        cmd_strobe = 1'b0;
        @(posedge core_clk) #1;
    endtask
    // Output transfer; data held while write strobe low and read strobe up
    task automatic out_cmd(input logic [5:0] tag, input logic [7:0] d, input logic perr);
        logic g;
        @(posedge core_clk) #1;
        cmd_tag = tag;
        cmd_strobe = 1'b1;
        drv = 1'b1;
        wd = d;
        bad = perr;
        @(posedge core_clk) #1;
        host_write_strobe = 1'b1;
        wait_rd(1'b1, g);
        host_write_strobe = 1'b0;
        wait_rd(1'b0, g);
        drv = 1'b0;
        cmd_strobe = 1'b0;
    endtask
    // Control tag: one strobe cycle, then let the effect land
    task automatic ctl_cmd(input logic [5:0] tag);
        @(posedge core_clk) #1;
        cmd_tag = tag;
        cmd_strobe = 1'b1;
        @(posedge core_clk) #1;
        cmd_strobe = 1'b0;
        @(posedge core_clk) #1;
    endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dsd_map.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top
    import dsd_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] cmd_tag;
    logic cmd_strobe, host_write_strobe, parity_in, parity_out, data_oe, drive_read_strobe;
    logic [7:0] data_in, data_out, head_addr, unit_id, rd;
    logic [9:0] cyl_pos;
    logic dev_init, check_switch, standby, seized_here, seized_other, single_port, ok;
    logic diag_escape, pos_busy, device_event_notice, pack_unsafe, heads_unload;
    logic interface_error;
    dsd_fault_t faults;
    dsd_pos_t pos;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    logic [15:0] r = 16'h51e5;
    dsd_status_cmds #(.BUSY_CYCLES(20)) i_dsd_status_cmds (.*);
    dsd_host_model i_host (.*);
    initial forever #5 core_clk = ~core_clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Summary byte with no errors and no busy positioner
    function automatic logic [7:0] summ(input logic esc);
        return {esc | seized_other, seized_here | single_port, standby, 5'h00};
    endfunction
    task automatic tick();
        @(posedge core_clk) #1;
    endtask
    task automatic q(input logic [5:0] t, input logic [7:0] e);
        i_host.in_cmd(t, rd, ok);
        `CHK("accepted", 1'b1, ok)
        `CHK($sformatf("answer to %h", t), e, rd)
        `CHK("parity_out", ~^e, parity_out)
        `CHK("data_oe", 1'b0, data_oe)
    endtask
    task automatic refused(input logic [5:0] t);
        i_host.in_cmd(t, rd, ok);
        `CHK("accepted", 1'b0, ok)
    endtask
    // Fault pulse by field mask: 20 supply, 10 spindle, 08 index, 02 reverse travel
    task automatic pulse_f(input dsd_fault_t m);
        faults = faults | m;
        tick();
        faults = faults & ~m;
        tick();
    endtask
    task automatic summarize();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard, well above the length of the sequence
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            summarize();
        end
    end
    initial
    begin
        {dev_init, check_switch, standby, seized_here, seized_other, single_port} = 6'h00;
        faults = '0;
        pos = '0;
        {head_addr, unit_id, cyl_pos} = '0;
        repeat (10) @(posedge core_clk);
        #1 rst = 1'b0;
        // Random live values; first pass puts the cylinder at its last legal value
        for (int i = 0; i < 8; i++)
        begin
            r = lfsr(r);
            {head_addr, unit_id} = r;
            r = lfsr(r);
            cyl_pos = (i == 0) ? 10'h336 : {1'b0, r[8:0]};
            {standby, seized_here, seized_other, single_port} = r[12:9];
            q(`DSD_TAG_HEAD_UP, 8'h00);
            q(`DSD_TAG_HEAD_LO, head_addr);
            q(`DSD_TAG_CYL_UP, {6'h00, cyl_pos[9:8]});
            q(`DSD_TAG_CYL_LO, cyl_pos[7:0]);
            q(`DSD_TAG_UNIT_NUM, unit_id);
            q(`DSD_TAG_UNIT_TYPE, `DSD_TYPE_CODE);
            q(`DSD_TAG_SUMMARY, summ(1'b0));
        end
        // Escape: normal queries blocked, sector counter stepped by hand only
        i_host.ctl_cmd(`DSD_TAG_DIAG_ESCAPE);
        `CHK("diag_escape", 1'b1, diag_escape)
        refused(`DSD_TAG_SUMMARY);
        refused(`DSD_TAG_HEAD_LO);
        pulse_f(6'h08);
        repeat (3) i_host.ctl_cmd(`DSD_TAG_SECT_STEP);
        refused(`DSD_TAG_ANGULAR);
        i_host.ctl_cmd(`DSD_TAG_DIAG_RESET);
        `CHK("diag_escape", 1'b0, diag_escape)
        // Count stepped in escape survives the return to normal mode
        q(`DSD_TAG_ANGULAR, 8'h03);
        q(`DSD_TAG_DETAIL3, 8'h00);
        refused(`DSD_TAG_DIAG_FIRST);
        i_host.ctl_cmd(`DSD_TAG_DIAG_ESCAPE);
        dev_init = 1'b1;
        tick();
        dev_init = 1'b0;
        tick();
        `CHK("diag_escape", 1'b0, diag_escape)
        // Index with the counter short of the last sector
        pulse_f(6'h08);
        q(`DSD_TAG_SUMMARY, summ(1'b0) | 8'h02);
        q(`DSD_TAG_DETAIL3, 8'h01);
        q(`DSD_TAG_DETAIL3, 8'h00);
        // Output transfers with bad and good parity, and seek direction record
        r = lfsr(r);
        i_host.out_cmd(`DSD_TAG_SEEK_FWD_LO, r[7:0], 1'b1);
        tick();
        `CHK("interface_error", 1'b1, interface_error)
        q(`DSD_TAG_DETAIL1, 8'h01);
        q(`DSD_TAG_DETAIL1, 8'h00);
        q(`DSD_TAG_DETAIL4, 8'h02);
        i_host.out_cmd(`DSD_TAG_SEEK_FWD_LO, r[15:8], 1'b1);
        tick();
        check_switch = 1'b1;
        tick();
        check_switch = 1'b0;
        tick();
        `CHK("interface_error", 1'b0, interface_error)
        i_host.out_cmd(`DSD_TAG_SEEK_REV_LO, r[15:8], 1'b0);
        tick();
        q(`DSD_TAG_DETAIL1, 8'h00);
        i_host.ctl_cmd(`DSD_TAG_DIAG_RESET);
        q(`DSD_TAG_DETAIL4, 8'h01);
        // Supply and spindle loss
        pulse_f(6'h20);
        `CHK("pack_unsafe", 1'b1, pack_unsafe)
        q(`DSD_TAG_DETAIL2, 8'h01);
        q(`DSD_TAG_DETAIL2, 8'h00);
        check_switch = 1'b1;
        tick();
        check_switch = 1'b0;
        tick();
        `CHK("pack_unsafe", 1'b0, pack_unsafe)
        pulse_f(6'h10);
        `CHK("heads_unload", 1'b1, heads_unload)
        dev_init = 1'b1;
        tick();
        dev_init = 1'b0;
        q(`DSD_TAG_DETAIL2, 8'h00);
        // Reverse travel past zero, first inside a return to zero
        pulse_f(6'h03);
        `CHK("interface_error", 1'b0, interface_error)
        pulse_f(6'h02);
        `CHK("interface_error", 1'b1, interface_error)
        q(`DSD_TAG_DETAIL3, 8'h02);
        // Offset shift: busy for the shortened time, then one notice
        pos.offset_shift = 1'b1;
        tick();
        pos.offset_shift = 1'b0;
        tick();
        `CHK("pos_busy", 1'b1, pos_busy)
        n = 0;
        while (device_event_notice !== 1'b1 && n < 40)
        begin
            tick();
            n++;
        end
        `CHK("busy length", 20 - 1, n)
        tick();
        `CHK("pos_busy", 1'b0, pos_busy)
        pos.seek_active = 1'b1;
        repeat (2) tick();
        `CHK("pos_busy", 1'b1, pos_busy)
        pos.seek_active = 1'b0;
        pos.zero_len_seek = 1'b1;
        repeat (2) tick();
        `CHK("pos_busy", 1'b1, pos_busy)
        pos.zero_len_seek = 1'b0;
        summarize();
    end
endmodule
`default_nettype wire
